//--- hw/xm_mgmt.sv
// Management slave, embedded-core init sequencer and resync engine
`timescale 1ns/1ns
`default_nettype none
module xm_mgmt #(
  parameter logic [15:0] ID_HI_VAL = 16'h0A5C, // Arbitrary identifier value
  parameter logic [15:0] ID_LO_VAL = 16'h0001, // Arbitrary identifier value
  parameter int WAIT_CYCLES = xm_pkg::WAIT_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Management pins
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  // Straps and core status
  input wire logic i_auto_cfg_en,
  input wire logic [4:0] i_port_address,
  input wire logic i_sync_lost,
  input wire logic i_link_up,
  input wire logic [15:0] i_lane_status,
  // Control outputs
  output logic o_loopback,
  output logic o_low_power_n,
  output logic o_cfg_busy,
  // Embedded core byte port
  output xm_pkg::xm_emb_req_type o_emb,
  input wire xm_pkg::xm_emb_rsp_type i_emb
);
  import xm_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_ST, M_HDR, M_TA, M_DAT} xm_md_type;
  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT, SQ_HOLD} xm_sq_type;

  // Pin synchronisers
  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2, cfg_s1, cfg_s2;
  logic [1:0] warm;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {mdc_s1, mdc_s2, mdc_s3} <= 3'h0;
      {mdio_s1, mdio_s2, cfg_s1, cfg_s2} <= 4'h0;
      warm <= 2'h0;
    end else begin
      {mdc_s1, mdc_s2, mdc_s3} <= {i_mdc, mdc_s1, mdc_s2};
      {mdio_s1, mdio_s2} <= {i_mdio, mdio_s1};
      {cfg_s1, cfg_s2} <= {i_auto_cfg_en, cfg_s1};
      warm <= {warm[0], 1'b1};
    end
  end
  wire mdc_rise = mdc_s2 & ~mdc_s3;

  // Frame receiver
  xm_md_type md_st;
  logic [5:0] pre_cnt;
  logic [4:0] bit_cnt;
  logic [11:0] hdr;
  logic [15:0] dat, reg_addr, rd_val, rd_sh;
  logic hit, resync_en, m_pend, m_wr, owner_seq, soft_rst;
  logic [7:0] m_wdata;
  wire [11:0] next_hdr = {hdr[10:0], mdio_s2};
  wire [15:0] next_dat = {dat[14:0], mdio_s2};
  wire [1:0] op_q = hdr[11:10];
  wire hdr_done = mdc_rise && md_st == M_HDR && bit_cnt == 5'(MD_HDR_LEN - 1);
  wire hdr_hit = next_hdr[9:5] == i_port_address && next_hdr[4:0] == MD_DEV_XS;
  wire hdr_rd = next_hdr[11:10] == MD_OP_READ || next_hdr[11:10] == MD_OP_RINC;
  wire ta_end = mdc_rise && md_st == M_TA && bit_cnt == 5'(MD_TA_LEN - 1);
  wire frm_done = mdc_rise && md_st == M_DAT && bit_cnt == 5'(MD_DAT_LEN - 1) && hit;
  wire is_emb = reg_addr[15:12] == RA_EMB_NIB;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      md_st <= M_IDLE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      hdr <= 12'h000;
      dat <= 16'h0000;
      hit <= 1'b0;
    end else if (mdc_rise) begin
      unique case (md_st)
        M_IDLE: begin
          if (mdio_s2) begin
            if (pre_cnt != 6'(MD_PRE_LEN)) pre_cnt <= pre_cnt + 6'h01;
          end else begin
            pre_cnt <= 6'h00;
            if (pre_cnt == 6'(MD_PRE_LEN)) md_st <= M_ST;
          end
        end
        M_ST: begin
          md_st <= mdio_s2 ? M_IDLE : M_HDR;
          bit_cnt <= 5'h00;
        end
        M_HDR: begin
          hdr <= next_hdr;
          bit_cnt <= bit_cnt + 5'h01;
          if (hdr_done) begin
            md_st <= M_TA;
            bit_cnt <= 5'h00;
            hit <= hdr_hit;
          end
        end
        M_TA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (ta_end) begin
            md_st <= M_DAT;
            bit_cnt <= 5'h00;
          end
        end
        M_DAT: begin
          dat <= next_dat;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == 5'(MD_DAT_LEN - 1)) md_st <= M_IDLE;
        end
      endcase
    end
  end

  // Register file
  wire wr_frm = frm_done && op_q == MD_OP_WRITE;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_addr <= 16'h0000;
      o_loopback <= 1'b0;
      o_low_power_n <= 1'b1;
      resync_en <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_frm && reg_addr == RA_CTRL1 && next_dat[CTRL_RST_BIT];
      if (frm_done && op_q == MD_OP_ADDR) reg_addr <= next_dat;
      if (frm_done && op_q == MD_OP_RINC) reg_addr <= reg_addr + 16'h0001;
      if (wr_frm && reg_addr == RA_CTRL1) begin
        o_loopback <= next_dat[CTRL_LB_BIT];
        o_low_power_n <= next_dat[CTRL_LP_BIT];
      end
      if (wr_frm && reg_addr == RA_VCTRL) resync_en <= next_dat[VCTRL_RSY_BIT];
    end
  end

  // Local read selection; self-clearing reset bit reads as busy
  wire [15:0] ctrl_rd = ({15'h0000, o_cfg_busy} << CTRL_RST_BIT)
      | ({15'h0000, o_loopback} << CTRL_LB_BIT) | ({15'h0000, o_low_power_n} << CTRL_LP_BIT);
  wire [15:0] stat1_rd = STAT1_LPA | ({15'h0000, i_link_up} << STAT1_LINK_BIT);
  wire [15:0] vctrl_rd = {15'h0000, resync_en} << VCTRL_RSY_BIT;
  wire [15:0] loc_rd = (reg_addr == RA_CTRL1) ? ctrl_rd :
      (reg_addr == RA_STAT1) ? stat1_rd :
      (reg_addr == RA_ID_HI) ? ID_HI_VAL :
      (reg_addr == RA_ID_LO) ? ID_LO_VAL :
      (reg_addr == RA_SPEED) ? SPEED_VAL :
      (reg_addr == RA_DEVS) ? DEVS_VAL :
      (reg_addr == RA_LANE) ? i_lane_status :
      (reg_addr == RA_VCTRL) ? vctrl_rd : 16'h0000;

  // Read data and line drive; TA gives ~200 cycles for an embedded read
  wire emb_rd_ack = i_emb.ack && !owner_seq && !o_emb.wr;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_val <= 16'h0000;
      rd_sh <= 16'h0000;
      o_mdio <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else begin
      if (hdr_done) rd_val <= loc_rd;
      if (emb_rd_ack) rd_val <= {8'h00, i_emb.rdata};
      if (mdc_rise && md_st == M_TA && bit_cnt == 5'h00 && hit && op_q[1]) begin
        o_mdio_oe <= 1'b1;
        o_mdio <= 1'b0;
      end
      if (ta_end && o_mdio_oe) begin
        o_mdio <= rd_val[15];
        rd_sh <= {rd_val[14:0], 1'b0};
      end
      if (mdc_rise && md_st == M_DAT) begin
        o_mdio <= rd_sh[15];
        rd_sh <= {rd_sh[14:0], 1'b0};
        if (bit_cnt == 5'(MD_DAT_LEN - 1)) o_mdio_oe <= 1'b0;
      end
    end
  end

  // Pending management access to the embedded port
  wire m_take = m_pend && !o_emb.req;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_pend <= 1'b0;
      m_wr <= 1'b0;
      m_wdata <= 8'h00;
    end else if (hdr_done && hdr_hit && hdr_rd && is_emb) begin
      m_pend <= 1'b1;
      m_wr <= 1'b0;
    end else if (wr_frm && is_emb) begin
      m_pend <= 1'b1;
      m_wr <= 1'b1;
      m_wdata <= next_dat[7:0];
    end else if (m_take) begin
      m_pend <= 1'b0;
    end
  end

  // Sequencer
  xm_sq_type sq_st;
  logic [5:0] idx, last;
  logic [15:0] hold_cnt;
  logic cfg_pend;
  xm_step_type step;
  assign step = xm_rom(idx);
  wire seq_take = sq_st == SQ_ISSUE && !o_emb.req && !m_pend;
  wire seq_ack = sq_st == SQ_WAIT && i_emb.ack;
  wire step_hold = step.rd && step.addr == EMB_SWRST;
  wire cfg_go = sq_st == SQ_IDLE && cfg_pend && warm[1];
  wire rsy_go = sq_st == SQ_IDLE && !cfg_pend && resync_en && i_sync_lost;
  assign o_cfg_busy = cfg_pend || sq_st != SQ_IDLE;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cfg_pend <= 1'b1;
    else if (soft_rst) cfg_pend <= 1'b1;
    else if (cfg_go) cfg_pend <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sq_st <= SQ_IDLE;
      idx <= IX_CFG_FIRST;
      last <= IX_CFG_LAST;
      hold_cnt <= 16'h0000;
    end else begin
      unique case (sq_st)
        SQ_IDLE: begin
          if (cfg_go && cfg_s2) begin
            idx <= IX_CFG_FIRST;
            last <= IX_CFG_LAST;
            sq_st <= SQ_ISSUE;
          end else if (rsy_go) begin
            idx <= IX_RSY_FIRST;
            last <= IX_RSY_LAST;
            sq_st <= SQ_ISSUE;
          end
        end
        SQ_ISSUE: if (seq_take) sq_st <= SQ_WAIT;
        SQ_WAIT: begin
          if (seq_ack && step_hold) begin
            sq_st <= SQ_HOLD;
            hold_cnt <= 16'(WAIT_CYCLES - 1);
          end else if (seq_ack) begin
            sq_st <= (idx == last) ? SQ_IDLE : SQ_ISSUE;
            idx <= (idx == last) ? idx : idx + 6'h01;
          end
        end
        SQ_HOLD: begin
          hold_cnt <= hold_cnt - 16'h0001;
          if (hold_cnt == 16'h0000) begin
            sq_st <= SQ_ISSUE;
            idx <= idx + 6'h01;
          end
        end
      endcase
    end
  end

  // Embedded port: management access beats the sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_emb <= '0;
      owner_seq <= 1'b0;
    end else if (!o_emb.req && m_pend) begin
      o_emb <= '{1'b1, m_wr, {EMB_BASE[7:0], reg_addr[11:0]}, m_wdata};
      owner_seq <= 1'b0;
    end else if (seq_take) begin
      o_emb <= '{1'b1, !step.rd, step.addr, step.data};
      owner_seq <= 1'b1;
    end else if (i_emb.ack) begin
      o_emb.req <= 1'b0;
    end
  end

  // Checks
  property p_legacy;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mdc_rise && md_st == M_ST && mdio_s2) |=> md_st == M_IDLE && !o_mdio_oe;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy frame not ignored");
  property p_pre;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mdc_rise && md_st == M_IDLE && !mdio_s2 && pre_cnt < 6'(MD_PRE_LEN)) |=> md_st == M_IDLE;
  endproperty
  a_pre: assert property (p_pre) else $error("frame began on short preamble");
  property p_drive;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_mdio_oe) |-> hit && op_q[1] && !o_mdio && hdr[4:0] == MD_DEV_XS;
  endproperty
  a_drive: assert property (p_drive) else $error("line driven for wrong frame");
  property p_inc;
    @(posedge i_clk) disable iff (!i_rst_n)
    (frm_done && op_q == MD_OP_RINC) |=> reg_addr == $past(reg_addr) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("address not advanced");
  property p_emb_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_emb.req && !i_emb.ack) |=> o_emb.req && $stable(o_emb);
  endproperty
  a_emb_hold: assert property (p_emb_hold) else $error("embedded request dropped");
  property p_map;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_emb.req && !owner_seq) |-> o_emb.addr[19:12] == EMB_BASE;
  endproperty
  a_map: assert property (p_map) else $error("embedded address not mapped");
  property p_skip;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cfg_go && !cfg_s2) |=> sq_st == SQ_IDLE && !cfg_pend;
  endproperty
  a_skip: assert property (p_skip) else $error("init ran with strap low");
  property p_start;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cfg_go && cfg_s2) |=> sq_st == SQ_ISSUE && idx == IX_CFG_FIRST ##1 o_emb.req[*1];
  endproperty
  a_start: assert property (p_start) else $error("init did not start at step 0");
  property p_resync;
    @(posedge i_clk) disable iff (!i_rst_n)
    ($rose(sq_st == SQ_ISSUE) && idx == IX_RSY_FIRST) |-> $past(resync_en);
  endproperty
  a_resync: assert property (p_resync) else $error("resync while disabled");
  // Hold length is a parameter, so count it rather than repeat a fixed number
  logic [15:0] hold_seen;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) hold_seen <= 16'h0000;
    else hold_seen <= (sq_st == SQ_HOLD) ? hold_seen + 16'h0001 : 16'h0000;
  end
  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    $fell(sq_st == SQ_HOLD) |-> hold_seen == 16'(WAIT_CYCLES) && !(o_emb.req && owner_seq);
  endproperty
  a_hold: assert property (p_hold) else $error("wait read too short");
  property p_order;
    @(posedge i_clk) disable iff (!i_rst_n)
    (seq_ack && !step_hold && idx != last) |=> idx == $past(idx) + 6'h01;
  endproperty
  a_order: assert property (p_order) else $error("init step skipped");
  c_legacy: cover property (@(posedge i_clk) mdc_rise && md_st == M_ST && mdio_s2);
  c_read: cover property (@(posedge i_clk) $rose(o_mdio_oe));
  c_done: cover property (@(posedge i_clk) seq_ack && idx == IX_CFG_LAST);
  c_rsy: cover property (@(posedge i_clk) rsy_go);
endmodule : xm_mgmt
`default_nettype wire

//--- hw/xm_pkg.sv
// Constants, types and embedded init table of the management block
package xm_pkg;
  localparam int MD_PRE_LEN = 32;
  localparam int MD_HDR_LEN = 12;
  localparam int MD_TA_LEN = 2;
  localparam int MD_DAT_LEN = 16;
  localparam logic [1:0] MD_OP_ADDR = 2'h0;
  localparam logic [1:0] MD_OP_WRITE = 2'h1;
  localparam logic [1:0] MD_OP_RINC = 2'h2;
  localparam logic [1:0] MD_OP_READ = 2'h3;
  localparam logic [4:0] MD_DEV_XS = 5'h04;
  localparam logic [15:0] RA_CTRL1 = 16'h0000;
  localparam logic [15:0] RA_STAT1 = 16'h0001;
  localparam logic [15:0] RA_ID_HI = 16'h0002;
  localparam logic [15:0] RA_ID_LO = 16'h0003;
  localparam logic [15:0] RA_SPEED = 16'h0004;
  localparam logic [15:0] RA_DEVS = 16'h0005;
  localparam logic [15:0] RA_LANE = 16'h0018;
  localparam logic [15:0] RA_VCTRL = 16'h8002;
  localparam logic [3:0] RA_EMB_NIB = 4'h9;
  localparam int CTRL_RST_BIT = 15;
  localparam int CTRL_LB_BIT = 14;
  localparam int CTRL_LP_BIT = 11;
  localparam int STAT1_LINK_BIT = 2;
  localparam int VCTRL_RSY_BIT = 15;
  localparam logic [15:0] STAT1_LPA = 16'h0002;
  localparam logic [15:0] SPEED_VAL = 16'h0001;
  localparam logic [15:0] DEVS_VAL = 16'h0010;
  localparam logic [7:0] EMB_BASE = 8'h30;
  localparam logic [19:0] EMB_SWRST = 20'h30105;
  localparam logic [5:0] IX_CFG_FIRST = 6'h00;
  localparam logic [5:0] IX_CFG_LAST = 6'h2A;
  localparam logic [5:0] IX_RSY_FIRST = 6'h2B;
  localparam logic [5:0] IX_RSY_LAST = 6'h2E;
  localparam int WAIT_NS = 1000;
  localparam int CLK_MHZ = 250;
  localparam int WAIT_CYC = (WAIT_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic rd;
    logic [19:0] addr;
    logic [7:0] data;
  } xm_step_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic [19:0] addr;
    logic [7:0] wdata;
  } xm_emb_req_type;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } xm_emb_rsp_type;

  function automatic xm_step_type xm_rom(input logic [5:0] ix);
    case (ix)
      6'h00: xm_rom = '{1'b0, 20'h30105, 8'h64};
      6'h01: xm_rom = '{1'b1, 20'h30105, 8'h00};
      6'h02: xm_rom = '{1'b1, 20'h30105, 8'h00};
      6'h03: xm_rom = '{1'b0, 20'h30105, 8'h44};
      6'h04: xm_rom = '{1'b0, 20'h30A00, 8'h00};
      6'h05: xm_rom = '{1'b0, 20'h30002, 8'h40};
      6'h06: xm_rom = '{1'b0, 20'h30003, 8'h40};
      6'h07: xm_rom = '{1'b0, 20'h30012, 8'h40};
      6'h08: xm_rom = '{1'b0, 20'h30013, 8'h40};
      6'h09: xm_rom = '{1'b0, 20'h30022, 8'h40};
      6'h0A: xm_rom = '{1'b0, 20'h30023, 8'h40};
      6'h0B: xm_rom = '{1'b0, 20'h30032, 8'h40};
      6'h0C: xm_rom = '{1'b0, 20'h30033, 8'h40};
      6'h0D: xm_rom = '{1'b0, 20'h30103, 8'h30};
      6'h0E: xm_rom = '{1'b0, 20'h30113, 8'h30};
      6'h0F: xm_rom = '{1'b0, 20'h30123, 8'h30};
      6'h10: xm_rom = '{1'b0, 20'h30133, 8'h30};
      6'h11: xm_rom = '{1'b0, 20'h30102, 8'h31};
      6'h12: xm_rom = '{1'b0, 20'h30112, 8'h31};
      6'h13: xm_rom = '{1'b0, 20'h30122, 8'h31};
      6'h14: xm_rom = '{1'b0, 20'h30132, 8'h31};
      6'h15: xm_rom = '{1'b0, 20'h30900, 8'hFF};
      6'h16: xm_rom = '{1'b0, 20'h30933, 8'h01};
      6'h17: xm_rom = '{1'b0, 20'h30920, 8'h01};
      6'h18: xm_rom = '{1'b0, 20'h30921, 8'h00};
      6'h19: xm_rom = '{1'b0, 20'h30104, 8'h40};
      6'h1A: xm_rom = '{1'b0, 20'h30114, 8'h40};
      6'h1B: xm_rom = '{1'b0, 20'h30124, 8'h40};
      6'h1C: xm_rom = '{1'b0, 20'h30134, 8'h40};
      6'h1D: xm_rom = '{1'b0, 20'h30901, 8'h00};
      6'h1E: xm_rom = '{1'b0, 20'h30910, 8'h0F};
      6'h1F: xm_rom = '{1'b0, 20'h30911, 8'h55};
      6'h20: xm_rom = '{1'b1, 20'h30904, 8'h00};
      6'h21: xm_rom = '{1'b1, 20'h30905, 8'h00};
      6'h22: xm_rom = '{1'b1, 20'h30914, 8'h00};
      6'h23: xm_rom = '{1'b0, 20'h30105, 8'h64};
      6'h24: xm_rom = '{1'b1, 20'h30105, 8'h00};
      6'h25: xm_rom = '{1'b1, 20'h30105, 8'h00};
      6'h26: xm_rom = '{1'b0, 20'h30105, 8'h44};
      6'h27: xm_rom = '{1'b0, 20'h30910, 8'h00};
      6'h28: xm_rom = '{1'b0, 20'h30910, 8'h0F};
      6'h29: xm_rom = '{1'b0, 20'h30920, 8'h01};
      6'h2A: xm_rom = '{1'b0, 20'h30920, 8'h03};
      6'h2B: xm_rom = '{1'b0, 20'h30910, 8'h0F};
      6'h2C: xm_rom = '{1'b0, 20'h30910, 8'hFF};
      6'h2D: xm_rom = '{1'b0, 20'h30920, 8'h01};
      6'h2E: xm_rom = '{1'b0, 20'h30920, 8'h03};
      default: xm_rom = '{1'b1, EMB_SWRST, 8'h00};
    endcase
  endfunction : xm_rom
endpackage : xm_pkg

//--- tb/xm_sta_model.sv
// Station manager model driving frames onto the management pins
`timescale 1ns/1ns
`default_nettype none
module xm_sta_model (
  // Management pins
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire logic i_mdio
);
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end

  // Clock only runs inside a frame; line released outside it
  task automatic xfer(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] dv, input logic [15:0] d, output logic [15:0] q);
    logic [63:0] f;
    logic rd;
    f = {32'hFFFFFFFF, st, op, pa, dv, 2'h2, d};
    rd = op[1];
    for (int i = 63; i >= 0; i--) begin
      o_mdio_oe = !(rd && i < 18);
      o_mdio = f[i];
      #63;
      o_mdc = 1'b1;
      if (i < 16) begin
        q[i] = i_mdio;
      end
      #62;
      o_mdc = 1'b0;
    end
    o_mdio_oe = 1'b0;
    o_mdio = 1'b1;
    // Idle gap keeps the next frame's first drive out of this time step
    #63;
  endtask : xfer
endmodule : xm_sta_model
`default_nettype wire

//--- tb/tb_top.sv
// Bench for the management block: init, frames, filters, resync
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import xm_pkg::*;
  localparam logic [4:0] PA = 5'h0B;
  localparam logic [11:0] BAD [4] = '{12'h484, 12'h160, 12'h165, 12'h184};
  localparam logic [31:0] TAB [47] = '{
    32'h03010564, 32'h13010500, 32'h13010500, 32'h03010544, 32'h030A0000,
    32'h03000240, 32'h03000340, 32'h03001240, 32'h03001340, 32'h03002240,
    32'h03002340, 32'h03003240, 32'h03003340, 32'h03010330, 32'h03011330,
    32'h03012330, 32'h03013330, 32'h03010231, 32'h03011231, 32'h03012231,
    32'h03013231, 32'h030900FF, 32'h03093301, 32'h03092001, 32'h03092100,
    32'h03010440, 32'h03011440, 32'h03012440, 32'h03013440, 32'h03090100,
    32'h0309100F, 32'h03091155, 32'h13090400, 32'h13090500, 32'h13091400,
    32'h03010564, 32'h13010500, 32'h13010500, 32'h03010544, 32'h03091000,
    32'h0309100F, 32'h03092001, 32'h03092003, 32'h0309100F, 32'h030910FF,
    32'h03092001, 32'h03092003};
  logic i_clk = 1'b0;
  logic rst_n = 1'b0;
  logic auto_cfg = 1'b0;
  logic sync_lost = 1'b0;
  logic mdc, sta_d, sta_en, dut_d, dut_oe, line, loopback, lp_n, busy;
  logic [15:0] q;
  xm_emb_req_type emb_req;
  xm_emb_rsp_type emb_rsp = '0;
  logic [31:0] log_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int lat = 0;
  int slow = 1;
  int oe_cnt = 0;

  assign line = dut_oe ? dut_d : (sta_en ? sta_d : 1'b1); // Pull-up on released line
  initial forever #2 i_clk = ~i_clk;

  xm_mgmt #(.WAIT_CYCLES(4)) u_dut (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_mdc(mdc), .i_mdio(line), .o_mdio(dut_d),
    .o_mdio_oe(dut_oe), .i_auto_cfg_en(auto_cfg), .i_port_address(PA),
    .i_sync_lost(sync_lost), .i_link_up(1'b1), .i_lane_status(16'h5A0F),
    .o_loopback(loopback), .o_low_power_n(lp_n), .o_cfg_busy(busy),
    .o_emb(emb_req), .i_emb(emb_rsp));
  xm_sta_model u_sta (.o_mdc(mdc), .o_mdio(sta_d), .o_mdio_oe(sta_en), .i_mdio(line));

  always @(posedge i_clk) begin
    if (dut_oe === 1'b1) begin
      oe_cnt <= oe_cnt + 1;
    end
  end

  // Embedded core stand-in; slow answers stretch the request hold
  always @(negedge i_clk) begin
    emb_rsp.ack <= 1'b0;
    if (emb_req.req === 1'b1 && !emb_rsp.ack) begin
      lat <= lat + 1;
      if (lat >= slow) begin
        lat <= 0;
        emb_rsp <= '{1'b1, emb_req.addr[7:0]};
        log_q.push_back({3'h0, ~emb_req.wr, emb_req.addr, emb_req.wr ? emb_req.wdata : 8'h00});
      end
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (8) @(negedge i_clk);
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    chk("cfg_busy", 32'h0, {31'h0, busy});
  endtask : wait_idle

  task automatic reset_dut(input logic strap);
    rst_n = 1'b0;
    auto_cfg = strap;
    repeat (12) @(negedge i_clk);
    log_q.delete();
    rst_n = 1'b1;
    wait_idle();
  endtask : reset_dut

  task automatic frm(input logic [1:0] op, input logic [15:0] d);
    u_sta.xfer(2'h0, op, PA, MD_DEV_XS, d, q);
  endtask : frm

  task automatic acc(input logic [1:0] op, input logic [15:0] a, input logic [15:0] d);
    frm(MD_OP_ADDR, a);
    frm(op, d);
  endtask : acc

  task automatic t_init();
    reset_dut(1'b0);
    chk("init accesses", 32'h0, log_q.size());
    reset_dut(1'b1);
    chk("init accesses", 32'h2B, log_q.size());
    for (int i = 0; i < 43; i++) begin
      chk("init step", TAB[i], log_q[i]);
    end
  endtask : t_init

  task automatic t_regs();
    acc(MD_OP_READ, RA_CTRL1, 16'h0000);
    chk("control", 32'h0800, q);
    acc(MD_OP_WRITE, RA_CTRL1, 16'h4000);
    chk("loopback", 32'h1, loopback);
    chk("low_power_n", 32'h0, lp_n);
    frm(MD_OP_WRITE, 16'h0800);
    chk("loopback", 32'h0, loopback);
    acc(MD_OP_RINC, RA_SPEED, 16'h0000);
    chk("speed", 32'h1, q);
    frm(MD_OP_READ, 16'h0000);
    chk("devices", 32'h10, q);
    acc(MD_OP_READ, RA_STAT1, 16'h0000);
    chk("status1", 32'h6, q);
    acc(MD_OP_READ, RA_LANE, 16'h0000);
    chk("lane status", 32'h5A0F, q);
  endtask : t_regs

  task automatic t_emb();
    log_q.delete();
    slow = 6;
    acc(MD_OP_WRITE, 16'h9123, 16'h00C3);
    frm(MD_OP_READ, 16'h0000);
    slow = 1;
    chk("embedded data", 32'h23, q);
    chk("embedded write", 32'h030123C3, log_q[0]);
    chk("embedded read", 32'h13012300, log_q[1]);
  endtask : t_emb

  // Legacy address frame first: taking it would move the stored address
  task automatic t_filter();
    int n;
    for (int i = 0; i < 4; i++) begin
      n = oe_cnt;
      u_sta.xfer(BAD[i][11:10], (i == 0) ? MD_OP_ADDR : MD_OP_READ, BAD[i][9:5],
          BAD[i][4:0], 16'h0000, q);
      chk("drive cycles", n, oe_cnt);
    end
    frm(MD_OP_READ, 16'h0000);
    chk("embedded accesses", 32'h3, log_q.size());
    chk("embedded data", 32'h23, q);
  endtask : t_filter

  task automatic t_resync();
    int n;
    n = 0;
    log_q.delete();
    sync_lost = 1'b1;
    repeat (200) @(negedge i_clk);
    chk("resync accesses", 32'h0, log_q.size());
    acc(MD_OP_WRITE, RA_VCTRL, 16'h8000);
    while (log_q.size() < 4 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    sync_lost = 1'b0;
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      chk("resync step", TAB[43 + i], log_q[i]);
    end
    chk("resync remainder", 32'h0, log_q.size() % 4);
    frm(MD_OP_READ, 16'h0000);
    chk("vendor control", 32'h8000, q);
    acc(MD_OP_WRITE, RA_VCTRL, 16'h0000);
    n = log_q.size();
    sync_lost = 1'b1;
    repeat (200) @(negedge i_clk);
    sync_lost = 1'b0;
    chk("resync accesses", n, log_q.size());
  endtask : t_resync

  task automatic t_softrst();
    log_q.delete();
    acc(MD_OP_WRITE, RA_CTRL1, 16'h8800);
    wait_idle();
    chk("init accesses", 32'h2B, log_q.size());
    chk("init step", TAB[0], log_q[0]);
  endtask : t_softrst

  initial begin
    @(negedge i_clk);
    t_init();
    t_regs();
    t_emb();
    t_filter();
    t_resync();
    t_softrst();
    wrap_up();
  end

  // Roughly 27 frames of 8 us each plus init runs
  initial begin
    #350000;
    mismatches++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
